// [inc/t2_defines.svh]
// Register offsets, field positions, reset values and divider counts of the timer
`ifndef T2_DEFINES_SVH
`define T2_DEFINES_SVH

// ==========================================================================
// Register byte offsets on the bus
`define T2_OFF_CTRL      8'h00
`define T2_OFF_CNT_LO    8'h04
`define T2_OFF_CNT_HI    8'h08
`define T2_OFF_RLD_LO    8'h0C
`define T2_OFF_RLD_HI    8'h10
`define T2_OFF_CLK_CTRL  8'h14
`define T2_OFF_GIE       8'h18

// ==========================================================================
// Control register fields
`define T2_CTRL_HOVF     7
`define T2_CTRL_LOVF     6
`define T2_CTRL_LIEN     5
`define T2_CTRL_CAPEN    4
`define T2_CTRL_SPLIT    3
`define T2_CTRL_RUN      2
`define T2_CTRL_XCLK     0

// Clock control and global interrupt enable fields
`define T2_CKC_HSEL      5
`define T2_CKC_LSEL      4
`define T2_GIE_TIMER     5

// ==========================================================================
// Reset values and divider counts
`define T2_RST_BYTE      8'h00
`define T2_BYTE_ONES     8'hFF
`define T2_SYS_DIV       12
`define T2_EXT_DIV       8

`endif

// [inc/t2_pkg.sv]
// Shared types of the timer
package t2_pkg;
  // One byte of counter, reload or register data
  typedef logic [7:0] t2_byte_t;
  // Bus transfer phase of the register slave
  typedef enum logic [0:0] {
    T2_BUS_IDLE,
    T2_BUS_WAIT
  } t2_bus_e;
endpackage

// [rtl/t2_prescale.sv]
// Free-running divider that yields one system-clock pulse every DIV cycles
`timescale 1ns/1ps
`default_nettype none
`include "t2_defines.svh"
module t2_prescale #(
  parameter int DIV = `T2_SYS_DIV
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  output logic      tick
);
  localparam int CW = $clog2(DIV);

  logic [CW-1:0] cnt_q;   // Cycle counter
  logic          tick_q;  // Registered output pulse

  // ==========================================================================
  // Divider: free running, so the tick phase does not depend on run control
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else if (cnt_q == CW'(DIV - 1)) begin
      cnt_q  <= '0;
      tick_q <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + CW'(1);
      tick_q <= 1'b0;
    end
  end

  assign tick = tick_q;
endmodule
`default_nettype wire

// [rtl/t2_ext_tick.sv]
// Synchroniser and divide-by-DIV of the external oscillator, one pulse per divided fall
`timescale 1ns/1ps
`default_nettype none
`include "t2_defines.svh"
module t2_ext_tick #(
  parameter int DIV = `T2_EXT_DIV
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic ext_osc,
  output logic      fall
);
  localparam int CW = $clog2(DIV);

  logic          sync1_q;  // First synchroniser stage, read only by the second
  logic          sync2_q;  // Second synchroniser stage
  logic          prev_q;   // Previous synchronised level for edge detection
  logic [CW-1:0] cnt_q;    // Divide counter; its top bit is the divided clock
  logic          fall_q;   // One-cycle pulse on the divided clock's falling edge

  // ==========================================================================
  // Two-stage synchroniser of the asynchronous oscillator pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q  <= 1'b0;
    end else begin
      sync1_q <= ext_osc;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // ==========================================================================
  // Divider: the divided clock falls when the counter wraps, giving one pulse
  // Limitation: the oscillator must stay well below half the system clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q  <= '0;
      fall_q <= 1'b0;
    end else begin
      fall_q <= 1'b0;
      if (sync2_q && !prev_q) begin
        cnt_q  <= cnt_q + CW'(1);
        fall_q <= (cnt_q == CW'(DIV - 1));
      end
    end
  end

  assign fall = fall_q;
endmodule
`default_nettype wire

// [rtl/t2_timer.sv]
// Sixteen-bit auto-reload and capture timer with an AHB-Lite register slave
//
// Function
// - Counter is a low and high byte
// - Split bit picks one 16-bit or two 8-bit
// - Ticks from system clock, /12, external /8
// - External tick synchronised before use
// - 16-bit wrap reloads and sets high flag
// - Timer enable requests irq on 16-bit overflow
// - Low enable adds irq on low wrap
// - Split mode reloads each byte on its wrap
// - Split mode: run gates high byte only
// - Per-half select picks system or alternate clock
// - Split mode flags per byte wrap
// - Split irq on high, either if low enabled
// - Flags never cleared by hardware
// - Capture mode timer clock from low select
// - Capture copies count to reload, sets flag
// - Capture on external /8 falling edge
// - Low select 1 counts every system clock
// - Capture enable bit turns capture on
// - Run bit enables the timer
`timescale 1ns/1ps
`default_nettype none
`include "t2_defines.svh"
module t2_timer #(
  parameter int SYS_DIV = `T2_SYS_DIV,
  parameter int EXT_DIV = `T2_EXT_DIV
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        ext_osc,
  output logic             timer_irq
);

  // ==========================================================================
  // Declarations
  t2_pkg::t2_byte_t count_low_byte_q;    // Counter low byte
  t2_pkg::t2_byte_t count_high_byte_q;   // Counter high byte
  t2_pkg::t2_byte_t reload_low_byte_q;   // Reload or capture low byte
  t2_pkg::t2_byte_t reload_high_byte_q;  // Reload or capture high byte
  logic             high_overflow_flag_q;
  logic             low_overflow_flag_q;
  logic             low_byte_irq_enable_q;
  logic             capture_enable_q;
  logic             split_mode_select_q;
  logic             run_control_q;
  logic             external_clock_select_q;
  logic             high_half_clock_select_q;
  logic             low_half_clock_select_q;
  logic             timer_irq_enable_q;    // Timer bit of the global enable
  logic             irq_q;                 // Registered interrupt request

  t2_pkg::t2_bus_e  bus_q;                 // Bus phase
  logic [7:0]       addr_q;                // Latched byte offset
  logic             write_q;               // Latched direction
  logic [31:0]      hrdata_q;
  logic             hreadyout_q;

  logic             div12_tick;            // System clock divided by 12
  logic             ext_fall;              // Divided external clock fall
  logic             lo_sel;                // Selected tick for the low half
  logic             hi_sel;                // Selected tick for the high half
  logic             lo_tick;               // Low byte advances this cycle
  logic             hi_tick;               // High byte advances this cycle
  logic             lo_wrap;               // Low byte wraps this cycle
  logic             hi_wrap;               // High byte wraps this cycle
  logic             capture;               // Capture event this cycle
  logic             wr_en;                 // Bus write strobe in data phase
  logic             rd_en;                 // Bus read strobe in data phase

  // ==========================================================================
  // Tick sources
  t2_prescale #(
    .DIV (SYS_DIV)
  ) u_prescale (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (div12_tick)
  );

  t2_ext_tick #(
    .DIV (EXT_DIV)
  ) u_ext_tick (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ext_osc (ext_osc),
    .fall    (ext_fall)
  );

  // Clock choice for one half: select 1 is every system clock, otherwise the
  // external bit chooses between the /12 tick and the divided oscillator
  function automatic logic pick_tick(input logic half_sel, input logic xclk,
                                     input logic d12, input logic ext);
    if (half_sel) begin
      pick_tick = 1'b1;
    end else if (xclk) begin
      pick_tick = ext;
    end else begin
      pick_tick = d12;
    end
  endfunction

  // Read view of the control register; bit 1 is reserved and reads zero
  function automatic logic [31:0] ctrl_view(input logic hf, input logic lf,
                                            input logic le, input logic ce,
                                            input logic sp, input logic rn,
                                            input logic xc);
    ctrl_view = 32'h0000_0000;
    ctrl_view[`T2_CTRL_HOVF]  = hf;
    ctrl_view[`T2_CTRL_LOVF]  = lf;
    ctrl_view[`T2_CTRL_LIEN]  = le;
    ctrl_view[`T2_CTRL_CAPEN] = ce;
    ctrl_view[`T2_CTRL_SPLIT] = sp;
    ctrl_view[`T2_CTRL_RUN]   = rn;
    ctrl_view[`T2_CTRL_XCLK]  = xc;
  endfunction

  // ==========================================================================
  // Counting decisions
  always_comb begin
    lo_sel = pick_tick(low_half_clock_select_q, external_clock_select_q,
                       div12_tick, ext_fall);
    hi_sel = pick_tick(high_half_clock_select_q, external_clock_select_q,
                       div12_tick, ext_fall);
    if (split_mode_select_q) begin
      // Low byte runs free; run control gates only the high byte
      lo_tick = lo_sel;
      hi_tick = hi_sel && run_control_q;
      lo_wrap = lo_tick && (count_low_byte_q == `T2_BYTE_ONES);
      hi_wrap = hi_tick && (count_high_byte_q == `T2_BYTE_ONES);
    end else begin
      // The whole 16-bit counter uses the low-half selection
      lo_tick = lo_sel && run_control_q;
      lo_wrap = lo_tick && (count_low_byte_q == `T2_BYTE_ONES);
      hi_tick = lo_wrap;
      hi_wrap = lo_wrap && (count_high_byte_q == `T2_BYTE_ONES);
    end
    capture = capture_enable_q && ext_fall;
  end

  // ==========================================================================
  // Bus strobes: every transfer spends one wait cycle so read data is a flop
  assign wr_en = (bus_q == t2_pkg::T2_BUS_WAIT) && write_q;
  assign rd_en = (bus_q == t2_pkg::T2_BUS_WAIT) && !write_q;

  // Address phase capture and wait-state sequencing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_q       <= t2_pkg::T2_BUS_IDLE;
      addr_q      <= 8'h00;
      write_q     <= 1'b0;
      hreadyout_q <= 1'b1;
    end else begin
      unique case (bus_q)
        t2_pkg::T2_BUS_IDLE: begin
          // Take a transfer only on a completed address phase
          if (hsel && htrans[1] && hready) begin
            bus_q       <= t2_pkg::T2_BUS_WAIT;
            addr_q      <= {haddr[7:2], 2'b00};
            write_q     <= hwrite;
            hreadyout_q <= 1'b0;
          end
        end
        t2_pkg::T2_BUS_WAIT: begin
          // Finish the data phase; the next address phase starts after it
          bus_q       <= t2_pkg::T2_BUS_IDLE;
          hreadyout_q <= 1'b1;
        end
      endcase
    end
  end

  // Read data, loaded in the wait cycle; unmapped offsets read zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rd_en) begin
      unique case (addr_q)
        `T2_OFF_CTRL: begin
          hrdata_q <= ctrl_view(high_overflow_flag_q, low_overflow_flag_q,
                                low_byte_irq_enable_q, capture_enable_q,
                                split_mode_select_q, run_control_q,
                                external_clock_select_q);
        end
        `T2_OFF_CNT_LO:   hrdata_q <= {24'h00_0000, count_low_byte_q};
        `T2_OFF_CNT_HI:   hrdata_q <= {24'h00_0000, count_high_byte_q};
        `T2_OFF_RLD_LO:   hrdata_q <= {24'h00_0000, reload_low_byte_q};
        `T2_OFF_RLD_HI:   hrdata_q <= {24'h00_0000, reload_high_byte_q};
        `T2_OFF_CLK_CTRL: begin
          hrdata_q <= (32'(high_half_clock_select_q) << `T2_CKC_HSEL)
                    | (32'(low_half_clock_select_q) << `T2_CKC_LSEL);
        end
        `T2_OFF_GIE:      hrdata_q <= 32'(timer_irq_enable_q) << `T2_GIE_TIMER;
        default:          hrdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // Control and configuration bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_byte_irq_enable_q    <= 1'b0;
      capture_enable_q         <= 1'b0;
      split_mode_select_q      <= 1'b0;
      run_control_q            <= 1'b0;
      external_clock_select_q  <= 1'b0;
      high_half_clock_select_q <= 1'b0;
      low_half_clock_select_q  <= 1'b0;
      timer_irq_enable_q       <= 1'b0;
    end else if (wr_en) begin
      if (addr_q == `T2_OFF_CTRL) begin
        low_byte_irq_enable_q   <= hwdata[`T2_CTRL_LIEN];
        capture_enable_q        <= hwdata[`T2_CTRL_CAPEN];
        split_mode_select_q     <= hwdata[`T2_CTRL_SPLIT];
        run_control_q           <= hwdata[`T2_CTRL_RUN];
        external_clock_select_q <= hwdata[`T2_CTRL_XCLK];
      end
      if (addr_q == `T2_OFF_CLK_CTRL) begin
        high_half_clock_select_q <= hwdata[`T2_CKC_HSEL];
        low_half_clock_select_q  <= hwdata[`T2_CKC_LSEL];
      end
      if (addr_q == `T2_OFF_GIE) begin
        timer_irq_enable_q <= hwdata[`T2_GIE_TIMER];
      end
    end
  end

  // ==========================================================================
  // Overflow flags: software writes them, a hardware set in the same cycle wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      high_overflow_flag_q <= 1'b0;
      low_overflow_flag_q  <= 1'b0;
    end else begin
      if (hi_wrap || capture) begin
        high_overflow_flag_q <= 1'b1;
      end else if (wr_en && addr_q == `T2_OFF_CTRL) begin
        high_overflow_flag_q <= hwdata[`T2_CTRL_HOVF];
      end
      // Low flag sets on any low wrap, whatever the mode
      if (lo_wrap) begin
        low_overflow_flag_q <= 1'b1;
      end else if (wr_en && addr_q == `T2_OFF_CTRL) begin
        low_overflow_flag_q <= hwdata[`T2_CTRL_LOVF];
      end
    end
  end

  // ==========================================================================
  // Counter bytes; a bus write wins over a tick in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_low_byte_q  <= `T2_RST_BYTE;
      count_high_byte_q <= `T2_RST_BYTE;
    end else begin
      if (wr_en && addr_q == `T2_OFF_CNT_LO) begin
        count_low_byte_q <= hwdata[7:0];
      end else if (lo_wrap && split_mode_select_q) begin
        count_low_byte_q <= reload_low_byte_q;
      end else if (hi_wrap && !split_mode_select_q) begin
        count_low_byte_q <= reload_low_byte_q;
      end else if (lo_tick) begin
        count_low_byte_q <= count_low_byte_q + 8'h01;
      end
      if (wr_en && addr_q == `T2_OFF_CNT_HI) begin
        count_high_byte_q <= hwdata[7:0];
      end else if (hi_wrap) begin
        count_high_byte_q <= reload_high_byte_q;
      end else if (hi_tick) begin
        count_high_byte_q <= count_high_byte_q + 8'h01;
      end
    end
  end

  // ==========================================================================
  // Reload bytes; a capture wins over a bus write so no measurement is lost
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reload_low_byte_q  <= `T2_RST_BYTE;
      reload_high_byte_q <= `T2_RST_BYTE;
    end else if (capture) begin
      reload_low_byte_q  <= count_low_byte_q;
      reload_high_byte_q <= count_high_byte_q;
    end else if (wr_en) begin
      if (addr_q == `T2_OFF_RLD_LO) begin
        reload_low_byte_q <= hwdata[7:0];
      end
      if (addr_q == `T2_OFF_RLD_HI) begin
        reload_high_byte_q <= hwdata[7:0];
      end
    end
  end

  // ==========================================================================
  // Interrupt request: a level that follows the flags one cycle later; the
  // handler tells the source apart by reading both flags
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= timer_irq_enable_q &&
               (high_overflow_flag_q ||
                (low_byte_irq_enable_q && low_overflow_flag_q));
    end
  end

  // ==========================================================================
  // Outputs
  assign hrdata    = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp     = 1'b0;
  assign timer_irq = irq_q;

endmodule
`default_nettype wire

// [bench/t2_timer_properties.sv]
// Port-level checker of the timer's bus slave and interrupt line
`timescale 1ns/1ps
`default_nettype none
`include "t2_defines.svh"
module t2_timer_properties (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        ext_osc,
  input wire logic        timer_irq
);
  // ==========================================================================
  // Shadow of the open data phase
  logic       pend_q; // Data phase open
  logic       wr_q;   // Open phase writes
  logic [7:0] addr_q; // Word offset of the open phase
  logic       gie_q;  // Timer irq enable, lands a cycle after the design's copy
  logic       taken;  // Address phase accepted
  logic       rd_end; // Read data phase ends here
  assign taken  = hsel && htrans[1] && hready;
  assign rd_end = pend_q && !wr_q && hready;
  // Late copy keeps the gate check safe on both edges of a change
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_q <= 1'b0;
      wr_q   <= 1'b0;
      addr_q <= 8'h00;
      gie_q  <= 1'b0;
    end else begin
      if (pend_q && hready) begin
        pend_q <= 1'b0;
        if (wr_q && addr_q == `T2_OFF_GIE) begin
          gie_q <= hwdata[`T2_GIE_TIMER];
        end
      end
      // A new phase taken at the same edge wins
      if (taken) begin
        pend_q <= 1'b1;
        wr_q   <= hwrite;
        addr_q <= {haddr[7:2], 2'b00};
      end
    end
  end
  // ==========================================================================
  // Properties
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence wait_one_s;
    !hreadyout ##1 hreadyout;
  endsequence
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("bus answer not okay");
  ready_wait_a: assert property (taken |=> wait_one_s)
    else $error("wait state not exactly one cycle");
  read_hold_a: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("read data moved outside a read");
  upper_zero_a: assert property (rd_end |-> hrdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  unmapped_zero_a: assert property (rd_end && addr_q > `T2_OFF_GIE |-> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  ctrl_spare_a: assert property (rd_end && addr_q == `T2_OFF_CTRL |-> !hrdata[1])
    else $error("spare control bit read as one");
  gie_gate_a: assert property (!gie_q |-> !timer_irq)
    else $error("interrupt without timer enable");
  sticky_irq_a: assert property (timer_irq && !pend_q |=> timer_irq)
    else $error("interrupt dropped without a write");
endmodule
bind t2_timer t2_timer_properties u_props (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .ext_osc(ext_osc), .timer_irq(timer_irq)
);
`default_nettype wire

// [bench/t2_timer_tb.sv]
// Self-checking bench of the timer: registers, reload, split, clock sources, capture
`timescale 1ns/1ps
`default_nettype none
`include "t2_defines.svh"
module t2_timer_tb;
  // ==========================================================================
  // Signals
  localparam int EXT_CYC = `T2_EXT_DIV * 70 / 8; // System clocks per divided ext tick
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        ext_osc;
  logic        timer_irq;
  int          miscompares;
  int          samples_checked;
  logic [31:0] rd; // Last read word
  logic [15:0] rv; // Random reload value
  logic [15:0] c1; // Successive captures
  logic [15:0] c2;
  int          wt[3] = '{100, 120, 700}; // Idle cycles per clock source
  t2_timer u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ext_osc(ext_osc), .timer_irq(timer_irq)
  );
  // ==========================================================================
  // Clocks: the oscillator is free running and unrelated in phase
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  initial begin
    ext_osc = 1'b0;
    #3;
    forever #35 ext_osc = ~ext_osc;
  end
  // ==========================================================================
  // Helpers
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Range compare; an unknown never passes
  task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    samples_checked++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      miscompares++;
      $display("ERROR %0t got %h expected %h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      miscompares++;
      $display("ERROR %0t wait %h reached %h", $time, n, lim);
      final_report();
    end
  endtask
  // One single transfer; request held until ready is seen high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h00_0000, a};
    hwrite <= w;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    tmo(n, 50);
    rd = hrdata;
  endtask
  task automatic rr(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, lo, hi);
  endtask
  task automatic wirq(input logic v);
    int n;
    n = 0;
    while (timer_irq !== v && n < 300) begin
      @(posedge hclk);
      n++;
    end
    tmo(n, 300);
    chk({31'h0, timer_irq}, {31'h0, v}, {31'h0, v});
  endtask
  // Waits for the high flag, reads the captured pair, clears the flag
  task automatic cap(output logic [15:0] c);
    int n;
    n = 0;
    do begin
      bus(1'b0, `T2_OFF_CTRL, 32'h0000_0000);
      n++;
    end while (rd[7] !== 1'b1 && n < 40);
    tmo(n, 40);
    bus(1'b0, `T2_OFF_RLD_LO, 32'h0000_0000);
    c[7:0] = rd[7:0];
    bus(1'b0, `T2_OFF_RLD_HI, 32'h0000_0000);
    c[15:8] = rd[7:0];
    bus(1'b1, `T2_OFF_CTRL, 32'h0000_0014);
  endtask
  // Count window after w idle cycles at d system clocks per tick
  function automatic logic [31:0] lo_of(input int w, input int d);
    return 32'((w - d) / d);
  endfunction
  function automatic logic [31:0] hi_of(input int w, input int d);
    return 32'((w + 8 + d) / d);
  endfunction
  // ==========================================================================
  // Main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    miscompares = 0;
    samples_checked = 0;
    void'($urandom(32'h16a8_aa87));
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values, the last offset is unmapped
    for (int i = 0; i < 8; i++) begin
      rr(8'(i * 4), 32'h0000_0000, 32'h0000_0000);
    end
    // Random bytes through count and reload while stopped
    for (int i = 1; i < 5; i++) begin
      rv = 16'($urandom());
      bus(1'b1, 8'(i * 4), {24'h00_0000, rv[7:0]});
      rr(8'(i * 4), {24'h00_0000, rv[7:0]}, {24'h00_0000, rv[7:0]});
    end
    bus(1'b1, `T2_OFF_CTRL, 32'h0000_0002);
    rr(`T2_OFF_CTRL, 32'h0000_0000, 32'h0000_0000);
    // Sixteen-bit wrap at system clock: reload, both flags, interrupts
    // High reload byte kept clear of 0xFF so no full wrap sets the high flag later
    rv = {8'($urandom_range(200)), 8'($urandom_range(128))};
    bus(1'b1, `T2_OFF_RLD_LO, {24'h00_0000, rv[7:0]});
    bus(1'b1, `T2_OFF_RLD_HI, {24'h00_0000, rv[15:8]});
    bus(1'b1, `T2_OFF_CNT_LO, 32'h0000_00FE);
    bus(1'b1, `T2_OFF_CNT_HI, 32'h0000_00FF);
    bus(1'b1, `T2_OFF_CLK_CTRL, 32'h0000_0010);
    bus(1'b1, `T2_OFF_CTRL, 32'h0000_0004);
    rr(`T2_OFF_CTRL, 32'h0000_00C4, 32'h0000_00C4);
    rr(`T2_OFF_CNT_HI, {24'h0, rv[15:8]}, {24'h0, rv[15:8]});
    rr(`T2_OFF_CNT_LO, {24'h0, rv[7:0]}, {24'h0, rv[7:0]} + 32'd40);
    bus(1'b1, `T2_OFF_GIE, 32'h0000_0020);
    wirq(1'b1);
    bus(1'b1, `T2_OFF_CTRL, 32'h0000_0004);
    wirq(1'b0);
    repeat (300) @(posedge hclk);
    chk({31'h0, timer_irq}, 32'h0, 32'h0);
    bus(1'b1, `T2_OFF_CTRL, 32'h0000_0024);
    wirq(1'b1);
    rr(`T2_OFF_CTRL, 32'h0000_0064, 32'h0000_0064);
    bus(1'b1, `T2_OFF_GIE, 32'h0000_0000);
    wirq(1'b0);
    // Split: low byte runs while high byte is stopped
    bus(1'b1, `T2_OFF_CTRL, 32'h0000_0008);
    bus(1'b1, `T2_OFF_CLK_CTRL, 32'h0000_0030);
    bus(1'b1, `T2_OFF_CNT_HI, 32'h0000_0055);
    repeat (300) @(posedge hclk);
    rr(`T2_OFF_CNT_HI, 32'h0000_0055, 32'h0000_0055);
    rr(`T2_OFF_CTRL, 32'h0000_0048, 32'h0000_0048);
    bus(1'b1, `T2_OFF_RLD_HI, 32'h0000_00C0);
    bus(1'b1, `T2_OFF_CNT_HI, 32'h0000_00FE);
    bus(1'b1, `T2_OFF_CTRL, 32'h0000_000C);
    bus(1'b0, `T2_OFF_CTRL, 32'h0000_0000);
    chk({31'h0, rd[7]}, 32'h1, 32'h1);
    rr(`T2_OFF_CNT_HI, 32'h0000_00C0, 32'h0000_00D8);
    bus(1'b1, `T2_OFF_GIE, 32'h0000_0020);
    wirq(1'b1);
    bus(1'b1, `T2_OFF_GIE, 32'h0000_0000);
    // Clock sources: system, divided by twelve, external divided
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, `T2_OFF_CTRL, (i == 2) ? 32'h0000_0005 : 32'h0000_0004);
      bus(1'b1, `T2_OFF_CLK_CTRL, (i == 0) ? 32'h0000_0010 : 32'h0000_0000);
      bus(1'b1, `T2_OFF_CNT_HI, 32'h0000_0000);
      bus(1'b1, `T2_OFF_CNT_LO, 32'h0000_0000);
      repeat (wt[i]) @(posedge hclk);
      bus(1'b0, `T2_OFF_CNT_LO, 32'h0000_0000);
      chk(rd, lo_of(wt[i], (i == 0) ? 1 : (i == 1) ? `T2_SYS_DIV : EXT_CYC),
          hi_of(wt[i], (i == 0) ? 1 : (i == 1) ? `T2_SYS_DIV : EXT_CYC));
    end
    // Capture: successive captures differ by one divided period
    bus(1'b1, `T2_OFF_CLK_CTRL, 32'h0000_0010);
    bus(1'b1, `T2_OFF_CNT_HI, 32'h0000_0000);
    bus(1'b1, `T2_OFF_CNT_LO, 32'h0000_0000);
    bus(1'b1, `T2_OFF_CTRL, 32'h0000_0014);
    cap(c1);
    cap(c2);
    chk({16'h0, c1}, 32'h1, EXT_CYC + 8);
    chk({16'h0, c2 - c1}, EXT_CYC - 2, EXT_CYC + 2);
    final_report();
  end
endmodule
`default_nettype wire
